// [inc/bia_consts.svh]
`ifndef BIA_CONSTS_SVH
`define BIA_CONSTS_SVH

// ----------------------------------------------------------------------
// Source counts and status word sizes
// ----------------------------------------------------------------------
`define BIA_NUM_CHAN 40
`define BIA_NUM_CNTR 6
`define BIA_WORD_W 16
`define BIA_NUM_WORDS 4

// ----------------------------------------------------------------------
// Status word layout
// ----------------------------------------------------------------------
`define BIA_W2_CHAN_BASE 32
`define BIA_W2_CHAN_CNT 8
`define BIA_W3_INDEX_LSB 4
`define BIA_W3_OVFL_LSB 10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BIA_EN_RST 1'b0
`define BIA_STAT_RST 16'h0000
`define BIA_IRQ_RST 1'b0

`endif

// [inc/bia_pkg.sv]
package bia_pkg;
  // Status words as seen by the host
  typedef struct packed {
    logic [15:0] word3;
    logic [15:0] word2;
    logic [15:0] word1;
    logic [15:0] word0;
  } bia_status_t;

  // Raw request flags from the capture logic
  typedef struct packed {
    logic [5:0] counter_overflow_request;
    logic [5:0] counter_index_request;
    logic [39:0] digital_io_channel;
  } bia_req_t;

  // Master enable write strobe with its data
  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } bia_en_wr_t;

  // Enable state machine
  typedef enum logic [1:0] {
    BIA_MASKED = 2'b01,
    BIA_ARMED = 2'b10
  } bia_state_t;
endpackage

// [rtl/bia_status_pack.sv]
`timescale 1ns/1ps
`include "bia_consts.svh"

module bia_status_pack
  import bia_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw flags in, packed words out
  input wire bia_pkg::bia_req_t req,
  output bia_pkg::bia_status_t stat_ff
);
  import bia_pkg::*;

  bia_status_t nxt_stat;

  // Pack flags into the four words; unused bits stay zero
  always_comb
  begin
    nxt_stat = '0;
    nxt_stat.word0 = req.digital_io_channel[`BIA_WORD_W-1:0];
    nxt_stat.word1 = req.digital_io_channel[2*`BIA_WORD_W-1:`BIA_WORD_W];
    nxt_stat.word2[`BIA_W2_CHAN_CNT-1:0] =
      req.digital_io_channel[`BIA_NUM_CHAN-1:`BIA_W2_CHAN_BASE];
    nxt_stat.word3[`BIA_W3_INDEX_LSB +: `BIA_NUM_CNTR] = req.counter_index_request;
    nxt_stat.word3[`BIA_W3_OVFL_LSB +: `BIA_NUM_CNTR] = req.counter_overflow_request;
  end

  // Register the words
  always_ff @(posedge clk)
  begin
    if (rst)
      stat_ff <= {`BIA_NUM_WORDS{`BIA_STAT_RST}};
    else
      stat_ff <= nxt_stat;
  end
endmodule

// [rtl/bia_top.sv]
// Behaviour
// - Writing zero to the master enable blocks the board interrupt, any nonzero value allows it.
// - A bus reset clears the master enable.
// - With the enable clear, requests stay visible in status but raise no interrupt.
// - The host may clear the master enable at any moment.
// - All source requests appear as four 16-bit status words.
// - Words 0 to 2 carry digital I/O requests, word 3 carries counter requests.
// - Word 0 bit n is channel n, word 1 bit n is channel n plus 16.
// - Word 2 bits 7..0 are channels 39..32, bits 15..8 read zero.
// - A status bit of one means its source is requesting service.
// - Word 3 holds overflow requests in bits 15..10, index requests in 9..4, zero in 3..0.
`timescale 1ns/1ps
`include "bia_consts.svh"

module bia_top
  import bia_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Bus reset from the host side
  input wire logic BUS_RST,
  // Source capture flags
  input wire logic [`BIA_NUM_CHAN-1:0] DIGITAL_IO_CHANNEL,
  input wire logic [`BIA_NUM_CNTR-1:0] COUNTER_OVERFLOW_REQUEST,
  input wire logic [`BIA_NUM_CNTR-1:0] COUNTER_INDEX_REQUEST,
  // Master enable write
  input wire bia_pkg::bia_en_wr_t EN_WR,
  // Host-visible state
  output bia_pkg::bia_status_t STATUS,
  output logic ENABLE,
  output logic IRQ
);
  import bia_pkg::*;

  // ----------------------------------------------------------------------
  // Status capture
  // ----------------------------------------------------------------------
  bia_req_t req;
  bia_status_t stat_ff;

  // Flags pass straight in; status is a mirror, never cleared by reads
  assign req = '{
    counter_overflow_request: COUNTER_OVERFLOW_REQUEST,
    counter_index_request: COUNTER_INDEX_REQUEST,
    digital_io_channel: DIGITAL_IO_CHANNEL
  };

  // Packing fixes the word layout of every source
  bia_status_pack u_pack (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .req(req),
    .stat_ff(stat_ff)
  );

  assign STATUS = stat_ff;

  // ----------------------------------------------------------------------
  // Master enable
  // ----------------------------------------------------------------------
  bia_state_t state_ff;
  bia_state_t nxt_state;

  // Any nonzero enable word arms the board, not only a single set bit
  function automatic logic en_value(input logic [`BIA_WORD_W-1:0] d);
    return |d;
  endfunction

  // Bus reset beats a same-cycle enable write so the board stays masked
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      BIA_MASKED:
      begin
        if (!BUS_RST && EN_WR.wr && en_value(EN_WR.data))
          nxt_state = BIA_ARMED;
      end
      BIA_ARMED:
      begin
        if (BUS_RST)
          nxt_state = BIA_MASKED;
        else if (EN_WR.wr && !en_value(EN_WR.data))
          nxt_state = BIA_MASKED;
      end
      // Illegal codes fall back to masked, the safe side for the host
      default:
        nxt_state = BIA_MASKED;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      state_ff <= BIA_MASKED;
    else
      state_ff <= nxt_state;
  end

  // ----------------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------------
  logic en_ff;
  logic irq_ff;
  logic nxt_en;
  logic nxt_irq;

  // OR of every raw request, shared by the gate and the checks
  function automatic logic any_request(input bia_req_t r);
    return |r;
  endfunction

  // Request summary for the checks below
  logic any_req;
  assign any_req = any_request(req);

  // Gate the OR of requests; pending bits remain while masked.
  // Taken from next values so IRQ never leads or lags STATUS by a cycle.
  always_comb
  begin
    nxt_en = (nxt_state == BIA_ARMED);
    nxt_irq = nxt_en && any_request(req);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      en_ff <= `BIA_EN_RST;
      irq_ff <= `BIA_IRQ_RST;
    end
    else
    begin
      en_ff <= nxt_en;
      irq_ff <= nxt_irq;
    end
  end

  assign ENABLE = en_ff;
  assign IRQ = irq_ff;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_zero_write;
    EN_WR.wr && !BUS_RST && (EN_WR.data == 16'h0000);
  endsequence

  sequence s_set_write;
    EN_WR.wr && !BUS_RST && (EN_WR.data != 16'h0000);
  endsequence

  // Flags held for a cycle with no reset edge in between
  sequence s_flags_steady;
    !$past(SYS_RST) && $stable(req);
  endsequence

  // Board interrupt up at the moment the host masks it
  sequence s_mask_while_up;
    IRQ ##0 s_zero_write;
  endsequence

  // Enable and interrupt follow the host's writes
  a_zero_masks: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_zero_write |=> !ENABLE && !IRQ)
    else $error("zero write did not mask");
  a_set_arms: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_set_write |=> ENABLE)
    else $error("nonzero write did not enable");
  a_busrst_masks: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    BUS_RST |=> !ENABLE)
    else $error("bus reset left enable set");
  a_busrst_quiet: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    BUS_RST |=> !IRQ)
    else $error("irq after bus reset");
  a_hold_armed: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ENABLE && !EN_WR.wr && !BUS_RST) |=> ENABLE)
    else $error("enable dropped without cause");
  a_hold_masked: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!ENABLE && !EN_WR.wr) |=> !ENABLE)
    else $error("enable rose without a write");
  a_mask_anytime: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_mask_while_up |=> !IRQ && !ENABLE)
    else $error("mask did not drop irq");

  // Interrupt is the gated OR of requests
  a_masked_quiet: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    !ENABLE |-> !IRQ)
    else $error("irq while masked");
  a_irq_has_source: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    IRQ |-> (|STATUS))
    else $error("irq without request");
  a_irq_follows: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (ENABLE && (|STATUS)) |-> IRQ)
    else $error("irq missing");
  a_irq_needs_req: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    IRQ |-> $past(any_req))
    else $error("irq without earlier request");
  a_rearm_raises: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (s_set_write ##0 any_req) |=> IRQ)
    else $error("rearm with pending request gave no irq");

  // Status words mirror the flags in the fixed layout
  a_word0_map: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1 |=> STATUS.word0 == $past(DIGITAL_IO_CHANNEL[15:0])
      && STATUS.word1 == $past(DIGITAL_IO_CHANNEL[31:16]))
    else $error("word 0/1 mapping wrong");
  a_word2_map: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1 |=> STATUS.word2 == {8'h00, $past(DIGITAL_IO_CHANNEL[39:32])})
    else $error("word 2 mapping wrong");
  a_word3_map: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    1'b1 |=> STATUS.word3 == {$past(COUNTER_OVERFLOW_REQUEST),
      $past(COUNTER_INDEX_REQUEST), 4'h0})
    else $error("word 3 mapping wrong");
  a_status_hold: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    s_flags_steady |=> $stable(STATUS))
    else $error("status moved with steady flags");
  a_pending_kept: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
    (!ENABLE && DIGITAL_IO_CHANNEL[0]) |=> STATUS.word0[0])
    else $error("masked request lost");

  // Every channel request stays visible while masked
  for (genvar i = 0; i < `BIA_NUM_CHAN; i++)
  begin : g_chan_kept
    a_chan_kept: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
      (!ENABLE && DIGITAL_IO_CHANNEL[i]) |=> STATUS[i])
      else $error("masked channel request lost");
  end
endmodule

// [sim/bia_host_model.sv]
`timescale 1ns/1ps

module bia_host_model
  import bia_pkg::*;
(
  // Clock and board interrupt
  input wire logic clk,
  input wire logic irq,
  // Source flags and enable writes
  output bia_pkg::bia_req_t req,
  output bia_pkg::bia_en_wr_t en_wr
);
  // -----------------
  // Host side
  // -----------------
  // Quiet until the bench asks for traffic
  initial
  begin
    req = '0;
    en_wr = '0;
  end

  // One-cycle enable write, launched off the falling edge
  task automatic write_en(input logic [15:0] d);
    @(negedge clk);
    en_wr = '{wr: 1'b1, data: d};
    @(negedge clk);
    en_wr = '0;
  endtask

  // Capture flags change off the falling edge
  task automatic set_flags(input logic [51:0] f);
    @(negedge clk);
    req = f;
    @(negedge clk);
  endtask

  // Mask, clear sources, only then unmask; bounded wait for the request
  task automatic service(output bit seen);
    seen = 1'b0;
    for (int i = 0; i < 20 && !seen; i++)
    begin
      @(negedge clk);
      seen = irq;
    end
    write_en(16'h0000);
    set_flags('0);
    write_en(16'h0001);
  endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  import bia_pkg::*;
  // -----------------
  // Bench signals
  // -----------------
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic bus_rst = 1'b0;
  bia_req_t req;
  bia_en_wr_t en_wr;
  bia_status_t status;
  logic enable;
  logic irq;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  bit seen;

  bia_top u_bia_top (
    .REF_CLK(ref_clk), .SYS_RST(sys_rst), .BUS_RST(bus_rst),
    .DIGITAL_IO_CHANNEL(req.digital_io_channel),
    .COUNTER_OVERFLOW_REQUEST(req.counter_overflow_request),
    .COUNTER_INDEX_REQUEST(req.counter_index_request), .EN_WR(en_wr),
    .STATUS(status), .ENABLE(enable), .IRQ(irq)
  );

  bia_host_model u_bia_host_model (.clk(ref_clk), .irq(irq), .req(req), .en_wr(en_wr));

  // 200 MHz clock
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic complete_run;
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_stat(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flg(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Hang guard, well past the short test sequence
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 400)
    begin
      error_cnt++;
      complete_run();
    end
  end

  // -----------------
  // Test sequence
  // -----------------
  initial
  begin
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk_stat(status, 64'h0);
    chk_flg({enable, irq}, 2'b00);
    u_bia_host_model.set_flags({6'h21, 6'h12, 40'ha5_1234_8001});
    chk_stat(status, 64'h8520_00a5_1234_8001);
    chk_flg({enable, irq}, 2'b00);
    u_bia_host_model.write_en(16'h0100);
    chk_flg({enable, irq}, 2'b11);
    chk_stat(status, 64'h8520_00a5_1234_8001);
    u_bia_host_model.service(seen);
    chk_flg({1'b0, seen}, 2'b01);
    chk_flg({enable, irq}, 2'b10);
    chk_stat(status, 64'h0);
    u_bia_host_model.set_flags({12'h0, 40'h80_0000_0000});
    chk_flg({enable, irq}, 2'b11);
    chk_stat(status, 64'h0000_0080_0000_0000);
    u_bia_host_model.write_en(16'h0000);
    chk_flg({enable, irq}, 2'b00);
    chk_stat(status, 64'h0000_0080_0000_0000);
    u_bia_host_model.write_en(16'h0001);
    chk_flg({enable, irq}, 2'b11);
    // Bus reset beats a same-cycle enable write
    @(negedge ref_clk);
    bus_rst = 1'b1;
    u_bia_host_model.write_en(16'hffff);
    bus_rst = 1'b0;
    chk_flg({enable, irq}, 2'b00);
    // Mid-run reset empties status; flags show again once released
    @(negedge ref_clk);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    chk_stat(status, 64'h0);
    chk_flg({enable, irq}, 2'b00);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    chk_stat(status, 64'h0000_0080_0000_0000);
    chk_flg({enable, irq}, 2'b00);
    complete_run();
  end
endmodule
